// ==== rtl/sdram_command_interface.sv ====
// Command-level model of a quad-bank synchronous DRAM.
module sdram_command_interface
  import sdram_pkg::*;
#(
  parameter int ROW_BITS      = sdram_pkg::ROW_W,
  parameter int SREF_INTERVAL = sdram_pkg::SREF_INT_CYC
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        clk_en_i,
  input  wire logic                        cke_i,
  input  wire logic                        cs_n_i,
  input  wire logic                        ras_n_i,
  input  wire logic                        cas_n_i,
  input  wire logic                        we_n_i,
  input  wire logic                        bank_select_lo_i,
  input  wire logic                        bank_select_hi_i,
  input  wire logic [sdram_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [sdram_pkg::DQM_W-1:0]  dqm_i,
  input  wire logic [sdram_pkg::DQ_W-1:0]   dq_i,
  output logic      [sdram_pkg::DQ_W-1:0]   dq_o,
  output logic      [sdram_pkg::DQ_W-1:0]   dq_oe_o,
  output logic                             self_refresh_o,
  output logic      [sdram_pkg::BANKS-1:0]  bank_open_o,
  output logic      [sdram_pkg::ROW_W-1:0]  refresh_row_o
);
  import sdram_pkg::*;

  localparam int MEM_AW = BANK_W + ROW_BITS + COL_W;
  localparam int LANE_W = DQ_W / DQM_W;
  localparam int SREF_W = $clog2(SREF_INTERVAL + 1);
  localparam logic [SREF_W-1:0] SREF_LAST = SREF_W'(SREF_INTERVAL - 1);
  localparam logic [1:0]        XSR_LAST  = 2'(XSR_MIN_CYC - 1);

  // Registered pin values
  cmd_t              cmd_s;
  logic              cke_s;
  logic [BANK_W-1:0] bank_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DQM_W-1:0]  dqm_s;
  logic [DQ_W-1:0]   dq_s;

  // Bank, mode and power state
  logic [BANKS-1:0]  open_r;
  logic [ROW_W-1:0]  row_r [BANKS];
  logic [MODE_W-1:0] mode_r;
  pwr_state_t        state_r;
  logic [SREF_W-1:0] sref_cnt_r;
  logic [1:0]        xsr_cnt_r;
  logic [ROW_W-1:0]  ref_row_r;

  // Burst engine
  logic              bst_act_r;
  logic              bst_rd_r;
  logic [BANK_W-1:0] bst_bank_r;
  logic [COL_W-1:0]  bst_col_r;
  logic [COL_W-1:0]  bst_idx_r;
  logic [COL_W-1:0]  bst_mask_r;
  logic              bst_endless_r;
  logic              bst_ap_r;

  // Read path
  logic              rd_v1_r;
  logic              rd_v2_r;
  logic [DQ_W-1:0]   rd_d2_r;
  logic [DQM_W-1:0]  dqm_d1_r;
  logic [DQ_W-1:0]   mem_rdata;
  logic [DQ_W-1:0]   dq_r;
  logic [DQ_W-1:0]   oe_r;
  logic              sref_out_r;

  sdram_cmd_decode u_decode (
    .clk_i   (ref_clk_i),
    .rst_i   (sys_rst_i),
    .ce_i    (clk_en_i),
    .cke_i   (cke_i),
    .cs_n_i  (cs_n_i),
    .ras_n_i (ras_n_i),
    .cas_n_i (cas_n_i),
    .we_n_i  (we_n_i),
    .bank_i  ({bank_select_hi_i, bank_select_lo_i}),
    .addr_i  (addr_i),
    .dqm_i   (dqm_i),
    .dq_i    (dq_i),
    .cmd_o   (cmd_s),
    .cke_o   (cke_s),
    .bank_o  (bank_s),
    .addr_o  (addr_s),
    .dqm_o   (dqm_s),
    .dq_o    (dq_s)
  );

  // Command qualification
  wire live       = (state_r == ST_NORMAL);
  // clock enable must be high for ordinary commands
  wire cmd_ok     = live & cke_s;
  wire is_rd_cmd  = (cmd_s == CMD_READ);
  wire is_wr_cmd  = (cmd_s == CMD_WRITE);
  // Accesses to an idle bank are dropped; the controller must activate first
  wire is_rw      = cmd_ok & (is_rd_cmd | is_wr_cmd) & open_r[bank_s];
  wire is_act     = cmd_ok & (cmd_s == CMD_ACTIVE);
  wire is_pre     = cmd_ok & (cmd_s == CMD_PRECHARGE);
  wire is_mode    = cmd_ok & (cmd_s == CMD_MODE);
  wire is_term    = cmd_ok & (cmd_s == CMD_TERM);
  wire auto_ref   = cmd_ok & (cmd_s == CMD_REFRESH);
  wire sref_enter = live & ~cke_s & (cmd_s == CMD_REFRESH);

  wire [2:0] bl_code    = mode_r[MODE_BL_LSB +: 3];
  wire       interleave = mode_r[MODE_BT_BIT];
  wire       wr_single  = mode_r[MODE_WB_BIT];
  wire       cl3        = (mode_r[MODE_CL_LSB +: 3] == CL_3);

  wire [COL_W-1:0] new_mask =
    (is_wr_cmd && wr_single) ? '0 : burst_mask(bl_code);
  wire new_endless = (bl_code == BL_FULL) & ~(is_wr_cmd & wr_single);

  // Current beat: a new command takes over from a running burst
  // terminate stops the running burst
  wire             beat_on   = is_rw | (bst_act_r & live & ~is_term);
  wire             beat_rd   = is_rw ? is_rd_cmd : bst_rd_r;
  wire [BANK_W-1:0] beat_bank = is_rw ? bank_s : bst_bank_r;
  wire [COL_W-1:0] beat_start = is_rw ? addr_s[COL_W-1:0] : bst_col_r;
  wire [COL_W-1:0] beat_idx   = is_rw ? '0 : bst_idx_r;
  wire [COL_W-1:0] beat_mask  = is_rw ? new_mask : bst_mask_r;
  wire             beat_endl  = is_rw ? new_endless : bst_endless_r;
  wire             beat_ap    = is_rw ? addr_s[AP_BIT] : bst_ap_r;
  wire             beat_last  = ~beat_endl & (beat_idx == beat_mask);
  wire [COL_W-1:0] beat_col   =
    beat_column(beat_start, beat_idx, beat_mask, interleave);

  // close bank after last beat, never in an endless full-page burst
  wire ap_close = beat_on & beat_last & beat_ap & ~beat_endl;

  wire [MEM_AW-1:0] mem_addr =
    {beat_bank, row_r[beat_bank][ROW_BITS-1:0], beat_col};
  // write data and mask taken with each beat
  wire mem_we = beat_on & ~beat_rd;

  sdram_array #(
    .ADDR_W (MEM_AW),
    .DATA_W (DQ_W),
    .LANES  (DQM_W)
  ) u_array (
    .clk_i     (ref_clk_i),
    .ce_i      (clk_en_i),
    .we_i      (mem_we),
    .lane_en_i (~dqm_s),
    .addr_i    (mem_addr),
    .wdata_i   (dq_s),
    .rdata_o   (mem_rdata)
  );

  // Bank table
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      open_r <= '0;
    end else if (clk_en_i) begin
      if (ap_close) begin
        open_r[beat_bank] <= 1'b0;
      end
      if (is_act) begin
        open_r[bank_s] <= 1'b1;
      end
      if (is_pre) begin
        if (addr_s[AP_BIT]) begin
          open_r <= '0;
        end else begin
          open_r[bank_s] <= 1'b0;
        end
      end
    end
  end

  // Row addresses need no reset; only the open flags carry meaning
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_row
      always_ff @(posedge ref_clk_i) begin
        if (clk_en_i && is_act && bank_s == BANK_W'(b)) begin
          row_r[b] <= addr_s[ROW_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mode_r <= MODE_RST;
    end else if (clk_en_i && is_mode) begin
      mode_r <= addr_s[MODE_W-1:0];
    end
  end

  // Burst sequencing
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bst_act_r     <= 1'b0;
      bst_rd_r      <= 1'b0;
      bst_bank_r    <= '0;
      bst_col_r     <= '0;
      bst_idx_r     <= '0;
      bst_mask_r    <= '0;
      bst_endless_r <= 1'b0;
      bst_ap_r      <= 1'b0;
    end else if (clk_en_i) begin
      bst_act_r <= beat_on & ~beat_last;
      bst_idx_r <= COL_W'(beat_idx + 1'b1);
      if (is_rw) begin
        bst_rd_r      <= is_rd_cmd;
        bst_bank_r    <= bank_s;
        bst_col_r     <= addr_s[COL_W-1:0];
        bst_mask_r    <= new_mask;
        bst_endless_r <= new_endless;
        bst_ap_r      <= addr_s[AP_BIT];
      end
    end
  end

  // Read pipeline: array data after one edge, a second stage for latency 3
  wire [DQ_W-1:0] out_d = cl3 ? rd_d2_r : mem_rdata;
  wire            out_v = cl3 ? rd_v2_r : rd_v1_r;
  logic [DQ_W-1:0] oe_nxt;

  // mask sampled two edges before the data edge
  genvar l;
  generate
    for (l = 0; l < DQM_W; l++) begin : g_oe
      assign oe_nxt[l*LANE_W +: LANE_W] = {LANE_W{out_v & ~dqm_d1_r[l]}};
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_v1_r  <= 1'b0;
      rd_v2_r  <= 1'b0;
      rd_d2_r  <= '0;
      dqm_d1_r <= '1;
      dq_r     <= '0;
      oe_r     <= '0;
    end else if (clk_en_i) begin
      rd_v1_r  <= beat_on & beat_rd;
      rd_v2_r  <= rd_v1_r;
      rd_d2_r  <= mem_rdata;
      dqm_d1_r <= dqm_s;
      dq_r     <= out_d;
      oe_r     <= oe_nxt;
    end
  end

  // Refresh and self refresh
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_r    <= ST_NORMAL;
      sref_cnt_r <= '0;
      xsr_cnt_r  <= '0;
      ref_row_r  <= '0;
      sref_out_r <= 1'b0;
    end else if (clk_en_i) begin
      sref_out_r <= (state_r != ST_NORMAL);
      case (state_r)
        ST_NORMAL: begin
          if (auto_ref) begin
            ref_row_r <= ROW_W'(ref_row_r + 1'b1);
          end
          // refresh with enable low enters self refresh
          if (sref_enter) begin
            state_r    <= ST_SREF;
            sref_cnt_r <= '0;
          end
        end
        ST_SREF: begin
          // only clock enable is watched here
          if (sref_cnt_r == SREF_LAST) begin
            sref_cnt_r <= '0;
            ref_row_r  <= ROW_W'(ref_row_r + 1'b1);
          end else begin
            sref_cnt_r <= SREF_W'(sref_cnt_r + 1'b1);
          end
          if (cke_s) begin
            state_r   <= ST_EXIT;
            xsr_cnt_r <= '0;
          end
        end
        ST_EXIT: begin
          // commands during exit are not executed
          if (xsr_cnt_r == XSR_LAST) begin
            state_r <= ST_NORMAL;
          end else begin
            xsr_cnt_r <= 2'(xsr_cnt_r + 1'b1);
          end
        end
        default: begin
          state_r <= ST_NORMAL;
        end
      endcase
    end
  end

  assign dq_o           = dq_r;
  assign dq_oe_o        = oe_r;
  assign self_refresh_o = sref_out_r;
  assign bank_open_o    = open_r;
  assign refresh_row_o  = ref_row_r;

endmodule

// ==== rtl/sdram_pkg.sv ====
// Constants, types and helpers shared by the DRAM command interface.
package sdram_pkg;

  localparam int BANK_W = 2;
  localparam int BANKS  = 4;
  localparam int ROW_W  = 13;
  localparam int COL_W  = 9;
  localparam int ADDR_W = 13;
  localparam int DQ_W   = 16;
  localparam int DQM_W  = 2;
  localparam int MODE_W = 12;

  localparam int AP_BIT      = 10;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_BIT = 9;

  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_3    = 3'h3;

  // Burst of one, sequential, latency three
  localparam logic [MODE_W-1:0] MODE_RST = 12'h030;

  localparam int T_REF_MS   = 64;
  localparam int N_REF_ROWS = 8192;
  localparam int CLK_MHZ    = 250;
  // Longest spacing between internal refreshes, rounded down
  localparam int SREF_INT_CYC = T_REF_MS * 1000 * CLK_MHZ / N_REF_ROWS;
  localparam int XSR_MIN_CYC  = 2;

  typedef enum logic [3:0] {
    CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
    CMD_TERM, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE
  } cmd_t;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_SREF   = 2'b01,
    ST_EXIT   = 2'b11
  } pwr_state_t;

  function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    cmd_t c;
    c = CMD_NOP;
    if (cs_n) begin
      c = CMD_INHIBIT;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'b111:  c = CMD_NOP;
        3'b011:  c = CMD_ACTIVE;
        3'b101:  c = CMD_READ;
        3'b100:  c = CMD_WRITE;
        3'b110:  c = CMD_TERM;
        3'b010:  c = CMD_PRECHARGE;
        3'b001:  c = CMD_REFRESH;
        default: c = CMD_MODE;
      endcase
    end
    return c;
  endfunction

  function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] bl);
    logic [COL_W-1:0] m;
    m = '0;
    case (bl)
      BL_2:    m = 9'h001;
      BL_4:    m = 9'h003;
      BL_8:    m = 9'h007;
      BL_FULL: m = 9'h1FF;
      default: m = 9'h000;
    endcase
    return m;
  endfunction

  // Block bits stay fixed; the low bits count or toggle inside the block
  function automatic logic [COL_W-1:0] beat_column(
      input logic [COL_W-1:0] start, input logic [COL_W-1:0] idx,
      input logic [COL_W-1:0] mask,  input logic interleave);
    logic [COL_W-1:0] low;
    low = interleave ? (start ^ idx) : COL_W'(start + idx);
    return (start & ~mask) | (low & mask);
  endfunction

endpackage

// ==== rtl/sdram_array.sv ====
// Byte-maskable storage array with registered read data.
module sdram_array #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter int LANES  = 2
) (
  input  wire logic              clk_i,
  input  wire logic              ce_i,
  input  wire logic              we_i,
  input  wire logic [LANES-1:0]  lane_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);
  localparam int LANE_W = DATA_W / LANES;

  // One store per lane, so every lane has a single writing process
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] mem [2**ADDR_W];
      logic [LANE_W-1:0] rd_r;

      // Masked lanes keep their old contents
      always_ff @(posedge clk_i) begin
        if (ce_i && we_i && lane_en_i[g]) begin
          mem[addr_i] <= wdata_i[g*LANE_W +: LANE_W];
        end
      end

      always_ff @(posedge clk_i) begin
        if (ce_i) begin
          rd_r <= mem[addr_i];
        end
      end

      assign rdata_o[g*LANE_W +: LANE_W] = rd_r;
    end
  endgenerate

endmodule

// ==== rtl/sdram_cmd_decode.sv ====
// Input register stage and command decode for the DRAM pins.
module sdram_cmd_decode
  import sdram_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic                        cke_i,
  input  wire logic                        cs_n_i,
  input  wire logic                        ras_n_i,
  input  wire logic                        cas_n_i,
  input  wire logic                        we_n_i,
  input  wire logic [sdram_pkg::BANK_W-1:0] bank_i,
  input  wire logic [sdram_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [sdram_pkg::DQM_W-1:0]  dqm_i,
  input  wire logic [sdram_pkg::DQ_W-1:0]   dq_i,
  output sdram_pkg::cmd_t                  cmd_o,
  output logic                             cke_o,
  output logic      [sdram_pkg::BANK_W-1:0] bank_o,
  output logic      [sdram_pkg::ADDR_W-1:0] addr_o,
  output logic      [sdram_pkg::DQM_W-1:0]  dqm_o,
  output logic      [sdram_pkg::DQ_W-1:0]   dq_o
);
  import sdram_pkg::*;

  cmd_t cmd_nxt;

  assign cmd_nxt = decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_o  <= CMD_INHIBIT;
      cke_o  <= 1'b1;
      bank_o <= '0;
      addr_o <= '0;
      dqm_o  <= '1;
      dq_o   <= '0;
    end else if (ce_i) begin
      cmd_o  <= cmd_nxt;
      cke_o  <= cke_i;
      bank_o <= bank_i;
      addr_o <= addr_i;
      dqm_o  <= dqm_i;
      dq_o   <= dq_i;
    end
  end

endmodule

// ==== tb/sdram_cmd_checker.sv ====
// Port-level assertions for the DRAM command interface.
module sdram_cmd_checker
  import sdram_pkg::*;
#(
  parameter int ROW_BITS      = sdram_pkg::ROW_W,
  parameter int SREF_INTERVAL = sdram_pkg::SREF_INT_CYC
) (
  input wire logic                         ref_clk_i,
  input wire logic                         sys_rst_i,
  input wire logic                         clk_en_i,
  input wire logic                         cke_i,
  input wire logic                         cs_n_i,
  input wire logic                         ras_n_i,
  input wire logic                         cas_n_i,
  input wire logic                         we_n_i,
  input wire logic                         bank_select_lo_i,
  input wire logic                         bank_select_hi_i,
  input wire logic [sdram_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sdram_pkg::DQM_W-1:0]  dqm_i,
  input wire logic [sdram_pkg::DQ_W-1:0]   dq_i,
  input wire logic [sdram_pkg::DQ_W-1:0]   dq_o,
  input wire logic [sdram_pkg::DQ_W-1:0]   dq_oe_o,
  input wire logic                         self_refresh_o,
  input wire logic [sdram_pkg::BANKS-1:0]  bank_open_o,
  input wire logic [sdram_pkg::ROW_W-1:0]  refresh_row_o
);
  default clocking dclk @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic [11:0] mode_r;
  logic [1:0]  sel_r;
  wire  [3:0]  pins    = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire  [1:0]  sel     = {bank_select_hi_i, bank_select_lo_i};
  wire  [15:0] lane_on = {{8{~dqm_i[1]}}, {8{~dqm_i[0]}}};
  wire         live    = clk_en_i && cke_i && !self_refresh_o;
  wire         act     = live && pins == 4'h3;
  wire         rd_go   = live && pins == 4'h5 && bank_open_o[sel];
  wire         pre     = live && pins == 4'h2;
  wire         aref    = live && pins == 4'h1;
  wire         sref    = clk_en_i && !cke_i && !self_refresh_o && pins == 4'h1;
  wire         cl3     = mode_r[6:4] == 3'h3 && mode_r[2:0] == 3'h0;

  // Mirror of the mode so latency-dependent checks pick the right figure
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mode_r <= 12'h030;
    end else if (live && pins == 4'h0) begin
      mode_r <= addr_i[11:0];
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rd_go) begin
      sel_r <= sel;
    end
  end

  sequence s_sref_in;
    sref ##1 !cke_i;
  endsequence
  sequence s_rd2;
    rd_go && mode_r[6:4] == 3'h2 && dqm_i == 2'h0;
  endsequence

  AST_ACT_OPEN: assert property (act |-> ##2 bank_open_o[$past(sel, 2)])
    else $error("bank not open after activate");
  AST_PRE_ONE: assert property (pre && !addr_i[10] |->
    ##2 !bank_open_o[$past(sel, 2)])
    else $error("bank still open after precharge");
  AST_PRE_ALL: assert property (pre && addr_i[10] |->
    ##2 bank_open_o == 4'h0)
    else $error("banks still open after precharge all");
  AST_RD_MASK: assert property (rd_go && cl3 |->
    ##4 dq_oe_o == $past(lane_on, 3))
    else $error("read drive does not follow mask");
  AST_RD_CL2: assert property (s_rd2 |-> ##3 dq_oe_o == 16'hFFFF)
    else $error("read beat missing at latency two");
  AST_AP_CLOSE: assert property (rd_go && addr_i[10]
    && mode_r[2:0] != 3'h7 |-> ##[2:5] !bank_open_o[sel_r])
    else $error("auto precharge did not close bank");
  AST_AREF_ROW: assert property (aref |->
    ##2 refresh_row_o == $past(refresh_row_o, 2) + 13'h0001)
    else $error("refresh row did not step");
  AST_SREF_IN: assert property (s_sref_in |-> ##2 self_refresh_o)
    else $error("self refresh not entered");
  AST_SREF_HOLD: assert property (self_refresh_o[*3] |->
    $stable(bank_open_o))
    else $error("bank state moved in self refresh");
  AST_SREF_EXIT: assert property (self_refresh_o && cke_i |->
    ##[1:8] !self_refresh_o)
    else $error("self refresh exit too slow");
endmodule

bind sdram_command_interface sdram_cmd_checker #(
  .ROW_BITS(ROW_BITS), .SREF_INTERVAL(SREF_INTERVAL)
) u_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .cke_i(cke_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i),
  .we_n_i(we_n_i), .bank_select_lo_i(bank_select_lo_i),
  .bank_select_hi_i(bank_select_hi_i), .addr_i(addr_i), .dqm_i(dqm_i),
  .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .self_refresh_o(self_refresh_o), .bank_open_o(bank_open_o),
  .refresh_row_o(refresh_row_o)
);

// ==== tb/sdram_ctrl_model.sv ====
// Behavioural memory controller turning bench requests into DRAM pins.
module sdram_ctrl_model
  import sdram_pkg::*;
(
  input  wire logic        clk_i,
  input  sdram_pkg::cmd_t  cmd_i,
  input  wire logic        cke_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  output logic             cke_o,
  output logic             cs_n_o,
  output logic             ras_n_o,
  output logic             cas_n_o,
  output logic             we_n_o,
  output logic      [15:0] dq_o
);
  logic [3:0]  pins;
  logic [15:0] last_r = 16'h0000;

  always_comb begin
    case (cmd_i)
      CMD_INHIBIT:   pins = 4'h8;
      CMD_ACTIVE:    pins = 4'h3;
      CMD_READ:      pins = 4'h5;
      CMD_WRITE:     pins = 4'h4;
      CMD_TERM:      pins = 4'h6;
      CMD_PRECHARGE: pins = 4'h2;
      CMD_REFRESH:   pins = 4'h1;
      CMD_MODE:      pins = 4'h0;
      default:       pins = 4'h7;
    endcase
  end
  assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = pins;
  assign cke_o = cke_i;
  assign dq_o = wr_i ? wdata_i : ~last_r;
  // Released bus toggles so a stale value never passes as write data
  always @(posedge clk_i) begin
    last_r <= dq_o;
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the DRAM command interface.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_pkg::*;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  cmd_t        cmd_r = CMD_NOP;
  logic        cke_r = 1'b1;
  logic        ce_r = 1'b1;
  logic        wr_r = 1'b0;
  logic [1:0]  bank_r = 2'h0;
  logic [12:0] addr_r = 13'h0000;
  logic [1:0]  dqm_r = 2'h0;
  logic [15:0] wd_r = 16'h0000;
  logic [31:0] seed = 32'h439C4210;
  wire         cke, cs_n, ras_n, cas_n, we_n;
  wire  [15:0] dq_w;
  logic [15:0] dq_o, dq_oe, ed, em;
  logic        sref;
  logic [3:0]  bank_open;
  logic [12:0] row, r0;
  logic [15:0] exp_d[$];
  logic [15:0] exp_m[$];
  logic [15:0] mem[4];
  logic [8:0]  cols[4];
  int          miscompares = 0;
  int          n_tests = 0;

  always #2 ref_clk = ~ref_clk;

  sdram_ctrl_model u_ctrl (
    .clk_i(ref_clk), .cmd_i(cmd_r), .cke_i(cke_r), .wr_i(wr_r),
    .wdata_i(wd_r), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .dq_o(dq_w));

  sdram_command_interface #(.ROW_BITS(4), .SREF_INTERVAL(8)) u_dut (
    .ref_clk_i(ref_clk), .sys_rst_i(rst), .clk_en_i(ce_r), .cke_i(cke),
    .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
    .bank_select_lo_i(bank_r[0]), .bank_select_hi_i(bank_r[1]),
    .addr_i(addr_r), .dqm_i(dqm_r), .dq_i(dq_w), .dq_o(dq_o),
    .dq_oe_o(dq_oe), .self_refresh_o(sref), .bank_open_o(bank_open),
    .refresh_row_o(row));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic drv(input cmd_t c, input logic [1:0] b, input logic [12:0] a,
                     input logic [1:0] m, input logic w, input logic [15:0] d);
    @(posedge ref_clk);
    cmd_r  <= c;
    bank_r <= b;
    addr_r <= a;
    dqm_r  <= m;
    wr_r   <= w;
    wd_r   <= d;
  endtask

  task automatic idle(input int n);
    repeat (n) drv(CMD_NOP, 2'h0, 13'h0000, 2'h0, 1'b0, 16'h0000);
  endtask

  // Latency three: the mask is taken the cycle after the read
  task automatic rd(input logic [1:0] b, input logic [12:0] a,
                    input logic [1:0] m, input logic [15:0] e);
    if (m != 2'h3) begin
      exp_d.push_back(e);
      exp_m.push_back({{8{~m[1]}}, {8{~m[0]}}});
    end
    drv(CMD_READ, b, a, 2'h0, 1'b0, 16'h0000);
    drv(CMD_NOP, b, 13'h0000, m, 1'b0, 16'h0000);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Any driven beat must match the oldest note
  always @(posedge ref_clk) begin
    if (!rst && dq_oe !== 16'h0000) begin
      if (exp_d.size() == 0) begin
        check(dq_oe, 16'h0000);
      end else begin
        ed = exp_d.pop_front();
        em = exp_m.pop_front();
        check(dq_oe, em);
        check(dq_o & dq_oe, ed & em);
      end
    end
  end

  initial begin
    repeat (2000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    idle(2);
    #1 check({12'h000, bank_open}, 16'h0000);
    for (int b = 0; b < 4; b++) begin
      seed = lfsr(seed);
      cols[b] = seed[8:0];
      drv(CMD_ACTIVE, 2'(b), seed[24:12], 2'h0, 1'b0, 16'h0000);
    end
    idle(6);
    #1 check({12'h000, bank_open}, 16'h000F);
    // full write, then low lane masked
    for (int b = 0; b < 4; b++) begin
      seed = lfsr(seed);
      mem[b] = seed[15:0];
      drv(CMD_WRITE, 2'(b), {4'h0, cols[b]}, 2'h0, 1'b1, mem[b]);
      drv(CMD_WRITE, 2'(b), {4'h0, cols[b]}, 2'h1, 1'b1, seed[31:16]);
      mem[b][15:8] = seed[31:24];
    end
    idle(2);
    // no mask, high lane masked, both lanes masked; last read auto precharged
    rd(2'h0, {4'h0, cols[0]}, 2'h0, mem[0]);
    rd(2'h1, {4'h0, cols[1]}, 2'h2, mem[1]);
    rd(2'h2, {4'h0, cols[2]}, 2'h3, mem[2]);
    rd(2'h3, {4'h2, cols[3]}, 2'h0, mem[3]);
    idle(6);
    #1 check({12'h000, bank_open}, 16'h0007);
    // single precharge, read to idle bank, precharge all
    drv(CMD_PRECHARGE, 2'h1, 13'h0000, 2'h0, 1'b0, 16'h0000);
    idle(5);
    #1 check({12'h000, bank_open}, 16'h0005);
    drv(CMD_READ, 2'h1, {4'h0, cols[1]}, 2'h0, 1'b0, 16'h0000);
    idle(6);
    drv(CMD_PRECHARGE, 2'h2, 13'h0400, 2'h0, 1'b0, 16'h0000);
    idle(5);
    #1 check({12'h000, bank_open}, 16'h0000);
    // refresh at row cycle spacing, address ignored
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      drv(CMD_REFRESH, seed[1:0], seed[14:2], 2'h0, 1'b0, 16'h0000);
      idle(17);
    end
    // Clock enable low freezes the pins: this refresh is lost
    ce_r <= 1'b0;
    drv(CMD_REFRESH, 2'h0, 13'h0000, 2'h0, 1'b0, 16'h0000);
    idle(2);
    ce_r <= 1'b1;
    idle(2);
    #1 check({3'h0, row}, 16'h0003);
    // banks idle, latency two, burst of two, cut read
    drv(CMD_MODE, 2'h0, 13'h0021, 2'h0, 1'b0, 16'h0000);
    idle(3);
    drv(CMD_ACTIVE, 2'h2, 13'h0005, 2'h0, 1'b0, 16'h0000);
    idle(6);
    seed = lfsr(seed);
    drv(CMD_WRITE, 2'h2, {4'h0, cols[2] & 9'h1FE}, 2'h0, 1'b1, seed[15:0]);
    drv(CMD_NOP, 2'h2, 13'h0000, 2'h0, 1'b1, seed[31:16]);
    idle(4);
    rd(2'h2, {4'h0, cols[2] & 9'h1FE}, 2'h0, seed[15:0]);
    exp_d.push_back(seed[31:16]);
    exp_m.push_back(16'hFFFF);
    idle(6);
    exp_d.push_back(seed[15:0]);
    exp_m.push_back(16'hFFFF);
    drv(CMD_READ, 2'h2, {4'h0, cols[2] & 9'h1FE}, 2'h0, 1'b0, 16'h0000);
    drv(CMD_TERM, 2'h2, 13'h0000, 2'h0, 1'b0, 16'h0000);
    idle(6);
    drv(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, 1'b0, 16'h0000);
    idle(5);
    drv(CMD_REFRESH, 2'h0, 13'h0000, 2'h0, 1'b0, 16'h0000);
    cke_r <= 1'b0;
    repeat (40) drv(CMD_ACTIVE, 2'h1, 13'h0001, 2'h0, 1'b0, 16'h0000);
    idle(1);
    #1 check({14'h0000, sref, |bank_open}, 16'h0002);
    check({15'h0000, row != 13'h0003}, 16'h0001);
    // exit with NOPs, then refresh resumes
    @(posedge ref_clk);
    cke_r <= 1'b1;
    idle(8);
    #1 check({15'h0000, sref}, 16'h0000);
    r0 = row;
    drv(CMD_REFRESH, 2'h0, 13'h0000, 2'h0, 1'b0, 16'h0000);
    idle(3);
    #1 check({3'h0, row}, {3'h0, r0 + 13'h0001});
    idle(4);
    check({15'h0000, exp_d.size() == 0}, 16'h0001);
    close_out();
  end
endmodule
